// >>> verilog/cfs_regs.vh
`ifndef CFS_REGS_VH
`define CFS_REGS_VH
// Register indices (word addresses on the plain port)
`define CFS_ADDR_CTRL      4'h0
`define CFS_ADDR_XCHG_MAX  4'h1
`define CFS_ADDR_XCHG_REC  4'h2
`define CFS_ADDR_FULL_CLR  4'h3
`define CFS_ADDR_FAST_DET  4'h4
`define CFS_ADDR_PRE_DET   4'h5
`define CFS_ADDR_DSG_DET   4'h6
`define CFS_ADDR_TRST_AMT  4'h7
`define CFS_ADDR_FAST_TO   4'h8
`define CFS_ADDR_PRE_TO    4'h9
`define CFS_ADDR_STATUS    4'ha
`define CFS_ADDR_FAST_TMR  4'hb
`define CFS_ADDR_PRE_TMR   4'hc
// Control register bit positions
`define CFS_CTRL_KEEP_CHG  0
`define CFS_CTRL_NONREM    1
`define CFS_CTRL_REMREC    2
`define CFS_CTRL_ZV_OFF    3
// Status register bit positions
`define CFS_ST_XCHG        0
`define CFS_ST_FAST_TO     1
`define CFS_ST_PRE_TO      2
`define CFS_ST_STOP        3
`define CFS_ST_FULL        4
`define CFS_ST_XALARM      5
// Reset values
`define CFS_RST_CTRL       16'h0000
`define CFS_RST_XCHG_MAX   16'h012c
`define CFS_RST_XCHG_REC   16'h0002
`define CFS_RST_FULL_CLR   16'h005f
`define CFS_RST_FAST_DET   16'h0320
`define CFS_RST_PRE_DET    16'h0032
`define CFS_RST_DSG_DET    16'h0064
`define CFS_RST_TRST_AMT   16'h0002
`define CFS_RST_FAST_TO    16'h2a30
`define CFS_RST_PRE_TO     16'h0e10
// Activity period: 1 s at 20 MHz
`define CFS_TICK_SEC       1
`define CFS_CLK_HZ         20000000
`define CFS_TICK_CYCLES    (`CFS_TICK_SEC * `CFS_CLK_HZ)
`endif

// >>> verilog/cfs_charge_fault_supervisor.v
// Operation
// RQ1 - Set excess-charge flag when charge added past full exceeds threshold.
// RQ2 - Zero excess-charge threshold disables the excess-charge fault.
// RQ3 - Excess charge: switches off, request zeroed, stop/full/excess alarms.
// RQ4 - Keep-charge-switch bit holds charge switch on during excess charge.
// RQ5 - Recover on pack low-high-low when removable and recovery option set.
// RQ6 - Non-removable: recover after enough continuous discharge at <=0 mA.
// RQ7 - Recover when state of charge falls to full-clear percent.
// RQ8 - On recovery restore switches, clear alarms and excess flag.
// RQ9 - Fast timer runs when current at or above fast detect threshold.
// RQ10 - Fast timer holds during pulse charge, throttling or after timeout.
// RQ11 - Fast timer reset by discharge amount or reset-input pulse (non-rem).
// RQ12 - Fast timeout: flag, switches off, request zero, stop alarm.
// RQ13 - Fast timeout recovers on discharge or broadcast bit pulse (removable).
// RQ14 - Fast recovery restores outputs, clears stop alarm and flag.
// RQ15 - Pre-charge timer runs at or above pre-charge detect threshold.
// RQ16 - Pre timer holds during pulse charge, throttling or after timeout.
// RQ17 - Pre timer reset by discharge amount or pack pulse (non-removable).
// RQ18 - Pre timeout: flag, switches off, request zero, stop alarm.
// RQ19 - Pre timeout recovers on discharge or pack pulse, then restores.
// RQ20 - All checks and timer updates happen once per one-second tick.
// RQ21 - Reset clears flags, alarms and timers; switches follow algorithm.
`timescale 1ns/1ns
`default_nettype none
`include "cfs_regs.vh"
module cfs_charge_fault_supervisor #(
   parameter TICK_CYCLES = `CFS_TICK_CYCLES
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Register port
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdata,
   // Measurements, same clock, valid at tick
   input  wire signed [15:0] measCurrent,
   input  wire [15:0] remainingCap,
   input  wire [15:0] fullChargeCap,
   input  wire [7:0]  relStateOfCharge,
   input  wire [15:0] chgReqCurrent,
   input  wire [15:0] chgReqVoltage,
   input  wire        algoChargeOn,
   input  wire        algoZeroVoltOn,
   input  wire        pulseChargingActive,
   input  wire        tempThrottleActive,
   input  wire        broadcastEnableBit,
   // Asynchronous pins
   input  wire        packPresentInput,
   input  wire        fastTimerResetInput,
   // Outputs
   output reg         chargeSwitch,
   output reg         zeroVoltPrechargeSwitch,
   output reg  [15:0] reqCurrent,
   output reg  [15:0] reqVoltage,
   output reg         excessChargeFlag,
   output reg         fastTimeoutFlag,
   output reg         preTimeoutFlag,
   output reg         stopChargeAlarm,
   output reg         fullAlarm,
   output reg         excessChargeAlarm,
   output reg         secTick
);

   // Configuration registers
   reg [15:0] ctrl_reg;
   reg [15:0] xMax_reg;
   reg [15:0] xRec_reg;
   reg [15:0] fullClr_reg;
   reg [15:0] fastDet_reg;
   reg [15:0] preDet_reg;
   reg [15:0] dsgDet_reg;
   reg [15:0] tRstAmt_reg;
   reg [15:0] fastTo_reg;
   reg [15:0] preTo_reg;
   // Internal state
   reg [31:0] tickCnt_reg;
   reg [1:0]  presSync_reg;
   reg [1:0]  cctSync_reg;
   reg [1:0]  presSeq_reg;
   reg [1:0]  cctSeq_reg;
   reg [1:0]  bcSeq_reg;
   reg [15:0] addedCap_reg;
   reg [15:0] dsgAcc_reg;
   reg [15:0] fastTmr_reg;
   reg [15:0] preTmr_reg;
   wire       tick;
   wire       keepChg;
   wire       nonRem;
   wire       remRec;
   wire       zvOff;
   wire       presPulse;
   wire       cctPulse;
   wire       bcPulse;
   wire       atFull;
   wire       charging;
   wire       discharging;
   wire [15:0] dsgMag;
   wire       tmrReset;
   wire       xSet;
   wire       xClr;
   wire       fSet;
   wire       fClr;
   wire       pSet;
   wire       pClr;
   wire       anyFault;

   assign tick    = (tickCnt_reg == TICK_CYCLES - 1);
   assign keepChg = ctrl_reg[`CFS_CTRL_KEEP_CHG];
   assign nonRem  = ctrl_reg[`CFS_CTRL_NONREM];
   assign remRec  = ctrl_reg[`CFS_CTRL_REMREC];
   assign zvOff   = ctrl_reg[`CFS_CTRL_ZV_OFF];
   assign atFull  = (remainingCap >= fullChargeCap);
   assign charging    = (measCurrent > 16'sh0000);
   assign discharging = (measCurrent <= 16'sh0000);
   assign dsgMag  = discharging ? (16'h0000 - measCurrent) : 16'h0000;

   // Low-high-low detection: sequence is 1 after high, pulse when pin is back low
   assign presPulse = (presSeq_reg == 2'h1) & ~presSync_reg[1];
   assign cctPulse  = (cctSeq_reg == 2'h1) & ~cctSync_reg[1];
   assign bcPulse   = (bcSeq_reg == 2'h1) & ~broadcastEnableBit;

   // Enough accumulated discharge amount resets both timers
   assign tmrReset = (dsgAcc_reg >= tRstAmt_reg) & discharging; // see RQ11

   // Excess-charge set and recovery terms
   assign xSet = (xMax_reg != 16'h0000) & atFull & charging &
                 (addedCap_reg + measCurrent[15:0] > xMax_reg); // see RQ1 RQ2
   assign xClr = (remRec & ~nonRem & presPulse) |                // see RQ5
                 (nonRem & discharging & (dsgAcc_reg >= xRec_reg)) | // see RQ6
                 (relStateOfCharge <= fullClr_reg[7:0]);         // see RQ7

   // Fast timeout terms
   assign fSet = (fastTo_reg != 16'h0000) &
                 (fastTmr_reg + 16'h0001 >= fastTo_reg) &
                 (measCurrent >= $signed(fastDet_reg)) &
                 ~pulseChargingActive & ~tempThrottleActive;     // see RQ12
   assign fClr = (dsgMag >= dsgDet_reg & discharging &
                  dsgDet_reg != 16'h0000) |
                 (~nonRem & bcPulse);                            // see RQ13

   // Pre-charge timeout terms
   assign pSet = (preTo_reg != 16'h0000) &
                 (preTmr_reg + 16'h0001 >= preTo_reg) &
                 (measCurrent >= $signed(preDet_reg)) &
                 ~pulseChargingActive & ~tempThrottleActive;     // see RQ18
   assign pClr = (dsgMag >= dsgDet_reg & discharging &
                  dsgDet_reg != 16'h0000) |
                 (~nonRem & presPulse);                          // see RQ19

   assign anyFault = excessChargeFlag | fastTimeoutFlag | preTimeoutFlag;

   // One-second activity tick
   always @(posedge clk) begin
      if (!rst_n) begin
         tickCnt_reg <= 32'h0000_0000;
         secTick     <= 1'b0;
      end else begin
         secTick <= tick;
         if (tick) begin
            tickCnt_reg <= 32'h0000_0000;       // see RQ20
         end else begin
            tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
         end
      end
   end

   // Pin synchronisers
   always @(posedge clk) begin
      if (!rst_n) begin
         presSync_reg <= 2'h0;
         cctSync_reg  <= 2'h0;
      end else begin
         presSync_reg <= {presSync_reg[0], packPresentInput};
         cctSync_reg  <= {cctSync_reg[0], fastTimerResetInput};
      end
   end

   // Pulse sequence trackers, sampled on the tick
   always @(posedge clk) begin
      if (!rst_n) begin
         presSeq_reg <= 2'h3;
         cctSeq_reg  <= 2'h3;
         bcSeq_reg   <= 2'h3;
      end else if (tick) begin
         // 3: waiting for low, 0: low seen, 1: high seen
         presSeq_reg <= ~presSync_reg[1] ? 2'h0 :
                        (presSeq_reg == 2'h0 ? 2'h1 : presSeq_reg);
         cctSeq_reg  <= ~cctSync_reg[1] ? 2'h0 :
                        (cctSeq_reg == 2'h0 ? 2'h1 : cctSeq_reg);
         bcSeq_reg   <= ~broadcastEnableBit ? 2'h0 :
                        (bcSeq_reg == 2'h0 ? 2'h1 : bcSeq_reg);
      end
   end

   // Charge and discharge accumulators, one current sample per second
   always @(posedge clk) begin
      if (!rst_n) begin
         addedCap_reg <= 16'h0000;
         dsgAcc_reg   <= 16'h0000;
      end else if (tick) begin
         if (atFull && charging) begin
            addedCap_reg <= addedCap_reg + measCurrent[15:0];
         end else if (!atFull) begin
            addedCap_reg <= 16'h0000;
         end
         if (discharging) begin
            dsgAcc_reg <= dsgAcc_reg + dsgMag;  // see RQ6
         end else begin
            dsgAcc_reg <= 16'h0000;             // continuity broken
         end
      end
   end

   // Charge timers
   always @(posedge clk) begin
      if (!rst_n) begin
         fastTmr_reg <= 16'h0000;               // see RQ21
         preTmr_reg  <= 16'h0000;
      end else if (tick) begin
         if (tmrReset || (nonRem && cctPulse)) begin
            fastTmr_reg <= 16'h0000;            // see RQ11
         end else if (measCurrent >= $signed(fastDet_reg) &&
                      !pulseChargingActive && !tempThrottleActive &&
                      !fastTimeoutFlag) begin   // see RQ9 RQ10
            fastTmr_reg <= fastTmr_reg + 16'h0001;
         end
         if (tmrReset || (nonRem && presPulse)) begin
            preTmr_reg <= 16'h0000;             // see RQ17
         end else if (measCurrent >= $signed(preDet_reg) &&
                      !pulseChargingActive && !tempThrottleActive &&
                      !preTimeoutFlag) begin    // see RQ15 RQ16
            preTmr_reg <= preTmr_reg + 16'h0001;
         end
      end
   end

   // Fault flags and alarms
   always @(posedge clk) begin
      if (!rst_n) begin
         excessChargeFlag  <= 1'b0;             // see RQ21
         fastTimeoutFlag   <= 1'b0;
         preTimeoutFlag    <= 1'b0;
         stopChargeAlarm   <= 1'b0;
         fullAlarm         <= 1'b0;
         excessChargeAlarm <= 1'b0;
      end else if (tick) begin
         if (excessChargeFlag ? xClr : xSet) begin
            excessChargeFlag  <= ~excessChargeFlag; // see RQ1 RQ8
            excessChargeAlarm <= ~excessChargeFlag; // see RQ3
            fullAlarm         <= ~excessChargeFlag;
         end
         if (fastTimeoutFlag ? fClr : fSet) begin
            fastTimeoutFlag <= ~fastTimeoutFlag; // see RQ12 RQ14
         end
         if (preTimeoutFlag ? pClr : pSet) begin
            preTimeoutFlag <= ~preTimeoutFlag;   // see RQ18 RQ19
         end
         stopChargeAlarm <=
            (excessChargeFlag ? ~xClr : xSet) |
            (fastTimeoutFlag ? ~fClr : fSet) |
            (preTimeoutFlag ? ~pClr : pSet);     // see RQ3 RQ14
      end
   end

   // Switches and charge request, algorithm pass-through unless faulted
   always @(posedge clk) begin
      if (!rst_n) begin
         chargeSwitch            <= 1'b0;
         zeroVoltPrechargeSwitch <= 1'b0;
         reqCurrent              <= 16'h0000;
         reqVoltage              <= 16'h0000;
      end else begin
         chargeSwitch <= algoChargeOn &
            ~(fastTimeoutFlag | preTimeoutFlag) &
            ~(excessChargeFlag & ~keepChg);      // see RQ4 RQ8
         zeroVoltPrechargeSwitch <= algoZeroVoltOn &
            ~(anyFault & zvOff);                 // see RQ3
         reqCurrent <= anyFault ? 16'h0000 : chgReqCurrent; // see RQ12
         reqVoltage <= anyFault ? 16'h0000 : chgReqVoltage; // see RQ18
      end
   end

   // Register writes
   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg    <= `CFS_RST_CTRL;
         xMax_reg    <= `CFS_RST_XCHG_MAX;
         xRec_reg    <= `CFS_RST_XCHG_REC;
         fullClr_reg <= `CFS_RST_FULL_CLR;
         fastDet_reg <= `CFS_RST_FAST_DET;
         preDet_reg  <= `CFS_RST_PRE_DET;
         dsgDet_reg  <= `CFS_RST_DSG_DET;
         tRstAmt_reg <= `CFS_RST_TRST_AMT;
         fastTo_reg  <= `CFS_RST_FAST_TO;
         preTo_reg   <= `CFS_RST_PRE_TO;
      end else if (regWr) begin
         case (regAddr)
            `CFS_ADDR_CTRL:     ctrl_reg    <= {12'h000, regWdata[3:0]};
            `CFS_ADDR_XCHG_MAX: xMax_reg    <= regWdata;
            `CFS_ADDR_XCHG_REC: xRec_reg    <= regWdata;
            `CFS_ADDR_FULL_CLR: fullClr_reg <= regWdata;
            `CFS_ADDR_FAST_DET: fastDet_reg <= regWdata;
            `CFS_ADDR_PRE_DET:  preDet_reg  <= regWdata;
            `CFS_ADDR_DSG_DET:  dsgDet_reg  <= regWdata;
            `CFS_ADDR_TRST_AMT: tRstAmt_reg <= regWdata;
            `CFS_ADDR_FAST_TO:  fastTo_reg  <= regWdata;
            `CFS_ADDR_PRE_TO:   preTo_reg   <= regWdata;
            default: begin
            end
         endcase
      end
   end

   // Register reads, data one cycle after the strobe
   always @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         case (regAddr)
            `CFS_ADDR_CTRL:     regRdata <= ctrl_reg;
            `CFS_ADDR_XCHG_MAX: regRdata <= xMax_reg;
            `CFS_ADDR_XCHG_REC: regRdata <= xRec_reg;
            `CFS_ADDR_FULL_CLR: regRdata <= fullClr_reg;
            `CFS_ADDR_FAST_DET: regRdata <= fastDet_reg;
            `CFS_ADDR_PRE_DET:  regRdata <= preDet_reg;
            `CFS_ADDR_DSG_DET:  regRdata <= dsgDet_reg;
            `CFS_ADDR_TRST_AMT: regRdata <= tRstAmt_reg;
            `CFS_ADDR_FAST_TO:  regRdata <= fastTo_reg;
            `CFS_ADDR_PRE_TO:   regRdata <= preTo_reg;
            `CFS_ADDR_STATUS:   regRdata <= {10'h000, excessChargeAlarm,
               fullAlarm, stopChargeAlarm, preTimeoutFlag,
               fastTimeoutFlag, excessChargeFlag};
            `CFS_ADDR_FAST_TMR: regRdata <= fastTmr_reg;
            `CFS_ADDR_PRE_TMR:  regRdata <= preTmr_reg;
            default:            regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// >>> dv/cfs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_chk #(
   parameter int TICK_CYCLES = 20
) (
   // Clock, reset, algorithm wishes
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] chgReqCurrent,
   input wire logic        algoChargeOn,
   // Protection outputs
   input wire logic        chargeSwitch,
   input wire logic [15:0] reqCurrent,
   input wire logic [15:0] reqVoltage,
   input wire logic        excessChargeFlag,
   input wire logic        fastTimeoutFlag,
   input wire logic        preTimeoutFlag,
   input wire logic        stopChargeAlarm,
   input wire logic        fullAlarm,
   input wire logic        excessChargeAlarm,
   input wire logic        secTick
);
   wire logic        anyF = excessChargeFlag | fastTimeoutFlag | preTimeoutFlag;
   wire logic        tmo  = fastTimeoutFlag | preTimeoutFlag;
   logic      [31:0] gap;
   logic             seen;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Cycles since the last tick marker
   always @(posedge clk) begin
      if (!rst_n) begin
         gap  <= 32'h0;
         seen <= 1'b0;
      end else begin
         gap  <= secTick ? 32'h0 : gap + 32'h1;
         seen <= seen | secTick;
      end
   end
   a_tick_period: assert property (
      secTick && seen |-> gap == TICK_CYCLES - 1)
      else $error("tick period wrong");
   a_tick_pulse: assert property (secTick |=> !secTick)
      else $error("tick marker too long");
   a_flag_on_tick: assert property (
      !$stable({anyF, tmo}) |-> secTick)
      else $error("flag moved off tick");
   a_tmo_switch: assert property (tmo |=> !chargeSwitch)
      else $error("switch on in timeout");
   a_fault_req: assert property (
      anyF |=> (reqCurrent | reqVoltage) == 16'h0)
      else $error("request not zero");
   a_excess_alarms: assert property (excessChargeFlag |->
      fullAlarm && excessChargeAlarm && stopChargeAlarm)
      else $error("excess alarms missing");
   a_tmo_stop: assert property (tmo |-> stopChargeAlarm)
      else $error("stop alarm missing");
   a_clear_follow: assert property (secTick && !anyF |=>
      chargeSwitch == $past(algoChargeOn) && reqCurrent == $past(chgReqCurrent))
      else $error("outputs not restored");
endmodule
bind cfs_charge_fault_supervisor cfs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk, .rst_n, .chgReqCurrent, .algoChargeOn, .chargeSwitch, .reqCurrent,
   .reqVoltage, .excessChargeFlag, .fastTimeoutFlag, .preTimeoutFlag,
   .stopChargeAlarm, .fullAlarm, .excessChargeAlarm, .secTick);
`default_nettype wire

// >>> dv/cfs_pin_pulse.sv
`timescale 1ns/1ns
`default_nettype none
module cfs_pin_pulse #(
   parameter int HOLD = 60
) (
   // Clock, reset, start and pin
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic go,
   output var  logic pin
);
   logic [7:0] cnt;
   // Idle low, high for HOLD cycles, back low; spans several ticks
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         pin <= 1'b0;
      end else if (go) begin
         cnt <= 8'(HOLD);
         pin <= 1'b1;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
         pin <= (cnt != 8'h01);
      end
   end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int          TK = 20;
   localparam logic [15:0] RV [10] = '{16'h0000, 16'h012c, 16'h0002,
      16'h005f, 16'h0320, 16'h0032, 16'h0064, 16'h0002, 16'h2a30, 16'h0e10};
   // Stimulus
   logic               clk, rst_n, regWr, regRd, goPack, goBc, goCct;
   logic               pulseChargingActive, tempThrottleActive;
   logic               algoChargeOn, algoZeroVoltOn, fastTimerResetInput;
   logic        [3:0]  regAddr;
   logic        [15:0] regWdata, remainingCap, fullChargeCap, rd, v;
   logic        [15:0] chgReqCurrent, chgReqVoltage;
   logic signed [15:0] measCurrent;
   logic        [7:0]  relStateOfCharge;
   // Observed
   logic               packPresentInput, broadcastEnableBit, secTick;
   logic               chargeSwitch, zeroVoltPrechargeSwitch;
   logic               excessChargeFlag, fastTimeoutFlag, preTimeoutFlag;
   logic               stopChargeAlarm, fullAlarm, excessChargeAlarm;
   logic        [15:0] regRdata, reqCurrent, reqVoltage;
   wire  logic  [2:0]  flg =
      {preTimeoutFlag, fastTimeoutFlag, excessChargeFlag};
   int                 errors = 0;
   int                 compares = 0;
   cfs_charge_fault_supervisor #(.TICK_CYCLES(TK)) u_dut (
      .clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .measCurrent, .remainingCap, .fullChargeCap, .relStateOfCharge,
      .chgReqCurrent, .chgReqVoltage, .algoChargeOn, .algoZeroVoltOn,
      .pulseChargingActive, .tempThrottleActive, .broadcastEnableBit,
      .packPresentInput, .fastTimerResetInput, .chargeSwitch,
      .zeroVoltPrechargeSwitch, .reqCurrent, .reqVoltage, .excessChargeFlag,
      .fastTimeoutFlag, .preTimeoutFlag, .stopChargeAlarm, .fullAlarm,
      .excessChargeAlarm, .secTick);
   cfs_pin_pulse u_pack (.clk, .rst_n, .go(goPack), .pin(packPresentInput));
   cfs_pin_pulse u_bc (.clk, .rst_n, .go(goBc), .pin(broadcastEnableBit));
   cfs_pin_pulse u_cct (.clk, .rst_n, .go(goCct), .pin(fastTimerResetInput));
   task automatic chk(input string n, input logic [15:0] g, e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask
   // Bounded wait for flags, then let outputs settle and compare
   task automatic waitf(input logic [2:0] m, w);
      for (int i = 0; i < 400 && (flg & m) !== w; i++) @(posedge clk) #1;
      repeat (2) @(posedge clk);
      #1 chk("flags", 16'(flg & m), 16'(w));
   endtask
   // Select 0 pack pin, 1 broadcast bit, 2 timer reset pin
   task automatic pin_pulse(input logic [1:0] s);
      @(posedge clk);
      if (s == 2'd1) goBc <= 1'b1;
      else if (s == 2'd2) goCct <= 1'b1;
      else goPack <= 1'b1;
      @(posedge clk);
      goBc <= 1'b0; goPack <= 1'b0; goCct <= 1'b0;
   endtask
   task automatic set_i(input logic signed [15:0] c);
      @(posedge clk);
      measCurrent <= c;
   endtask
   task automatic fault_outs(input logic sw);
      chk("switch", 16'(chargeSwitch), 16'(sw));
      chk("request", reqCurrent | reqVoltage, 16'h0);
      chk("stop", 16'(stopChargeAlarm), 16'h1);
   endtask
   task automatic clear_outs;
      chk("switch", 16'(chargeSwitch), 16'h1);
      chk("current", reqCurrent, 16'h01f4);
      chk("voltage", reqVoltage, 16'h3070);
      v = 16'({stopChargeAlarm, fullAlarm, excessChargeAlarm});
      chk("alarms", v, 16'h0);
   endtask
   task automatic t_reset;
      #1 chk("idle", 16'({flg, stopChargeAlarm, fullAlarm}), 16'h0);
      for (int i = 0; i < 10; i++) begin
         rdr(4'(i));
         chk("reset value", rd, RV[i]);
      end
      rdr(4'hb);
      chk("fast timer", rd, 16'h0);
      rdr(4'hf);
      chk("unmapped", rd, 16'h0);
      $display("test reset done");
   endtask
   task automatic t_fast;
      wr(4'h8, 16'h0003);
      set_i(16'sd1000);
      waitf(3'b010, 3'b010);
      fault_outs(1'b0);
      rdr(4'hb); v = rd;
      repeat (2 * TK) @(posedge clk);
      rdr(4'hb);
      chk("held timer", rd, v);
      set_i(16'sd0);
      pin_pulse(1'b1);
      waitf(3'b010, 3'b000);
      clear_outs();
      $display("test fast timeout done");
   endtask
   task automatic t_susp;
      wr(4'h8, 16'h0000);
      set_i(16'sd1000);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         pulseChargingActive <= (k == 0);
         tempThrottleActive <= (k == 1);
         rdr(4'hb); v = rd;
         repeat (3 * TK) @(posedge clk);
         rdr(4'hb);
         chk("timer moves", 16'(rd != v), 16'(k == 2));
      end
      chk("disabled", 16'(flg), 16'h0);
      set_i(16'sd0);
      $display("test suspend done");
   endtask
   task automatic t_pre;
      wr(4'h9, 16'h0003);
      set_i(16'sd60);
      waitf(3'b100, 3'b100);
      fault_outs(1'b0);
      set_i(16'sd0);
      pin_pulse(1'b0);
      waitf(3'b100, 3'b000);
      clear_outs();
      $display("test pre timeout done");
   endtask
   task automatic t_excess;
      wr(4'h1, 16'h000a);
      for (int k = 0; k < 2; k++) begin
         wr(4'h0, k ? 16'h0001 : 16'h0008);
         @(posedge clk);
         remainingCap <= 16'd1000; relStateOfCharge <= 8'd100;
         set_i(16'sd5);
         waitf(3'b001, 3'b001);
         fault_outs(k[0]);
         chk("zero volt", 16'(zeroVoltPrechargeSwitch), 16'(k));
         chk("alarms", 16'({fullAlarm, excessChargeAlarm}), 16'h3);
         @(posedge clk);
         remainingCap <= 16'd900; relStateOfCharge <= 8'd95;
         waitf(3'b001, 3'b000);
         clear_outs();
      end
      wr(4'h1, 16'h0000);
      @(posedge clk);
      remainingCap <= 16'd1000; relStateOfCharge <= 8'd100;
      repeat (8 * TK) @(posedge clk);
      #1 chk("disabled", 16'({excessChargeFlag, fullAlarm}), 16'h0);
      $display("test excess charge done");
   endtask
   // Pin pulses clear timers when non-removable; other recovery paths
   task automatic t_recover;
      wr(4'h9, 16'h0000);
      wr(4'h0, 16'h0002);
      set_i(16'sd1000);
      for (int k = 0; k < 2; k++) begin
         repeat (4 * TK) @(posedge clk);
         rdr(k ? 4'hc : 4'hb); v = rd;
         pin_pulse(k ? 2'd0 : 2'd2);
         repeat (5 * TK) @(posedge clk);
         rdr(k ? 4'hc : 4'hb);
         chk("timer cleared", 16'(rd < v), 16'h1);
      end
      wr(4'h1, 16'h000a);
      for (int k = 0; k < 2; k++) begin
         wr(4'h0, k ? 16'h0004 : 16'h0002);
         @(posedge clk);
         remainingCap <= 16'd1000; relStateOfCharge <= 8'd100;
         set_i(16'sd5);
         waitf(3'b001, 3'b001);
         set_i(k ? 16'sd0 : -16'sd3);
         if (k) pin_pulse(2'd0);
         waitf(3'b001, 3'b000);
      end
      $display("test recovery paths done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Main sequence
   initial begin
      {rst_n, regWr, regRd, goPack, goBc, pulseChargingActive} = 6'h0;
      {goCct, tempThrottleActive, regAddr, regWdata} = 0;
      {algoChargeOn, algoZeroVoltOn} = 2'b11;
      {chgReqCurrent, chgReqVoltage} = {16'h01f4, 16'h3070};
      {remainingCap, fullChargeCap, measCurrent} = {16'd500, 16'd1000, 16'sd0};
      relStateOfCharge = 8'd50;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_fast();
      t_susp();
      t_pre();
      t_excess();
      t_recover();
      print_verdict();
   end
   // Watchdog
   initial begin
      #(20000 * 50);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
